// ### hw/wdcr_defs.svh
// offsets, field positions, reset values and timing counts of the watchdog count readback block
// assumes a 32-bit APB slave, one register per aligned word
`ifndef WDCR_DEFS_SVH
`define WDCR_DEFS_SVH

// ****************************************************
// register byte addresses
// ****************************************************
`define WDCR_OFF_PERIOD   8'h00
`define WDCR_OFF_CLKWIN   8'h04
`define WDCR_OFF_PSLOW    8'h08
`define WDCR_OFF_PSHIGH   8'h0C
`define WDCR_OFF_TIMER    8'h10

// ****************************************************
// field positions
// ****************************************************
`define WDCR_SEN_BIT      0
`define WDCR_PS_LSB       1
`define WDCR_PS_MSB       5
`define WDCR_CS_LSB       4
`define WDCR_CS_MSB       6
`define WDCR_WIN_LSB      0
`define WDCR_WIN_MSB      2
`define WDCR_TMR_ARMED    2
`define WDCR_TMR_CNT_LSB  3
`define WDCR_TMR_CNT_MSB  6

// ****************************************************
// reset values
// ****************************************************
`define WDCR_RST_PS       5'h00
`define WDCR_RST_CS       3'h0
`define WDCR_RST_WIN      3'h7
`define WDCR_RST_PRESCALE_COUNT    18'h00000
`define WDCR_RST_CNT      4'h0

// ****************************************************
// timing: watchdog clock periods in ns, system clock 50 ns
// ****************************************************
`define WDCR_CLK_NS       50
`define WDCR_LF_NS        32258
`define WDCR_MF_NS        32000
`define WDCR_LF_CYC       ((`WDCR_LF_NS + `WDCR_CLK_NS - 1) / `WDCR_CLK_NS)
`define WDCR_MF_CYC       ((`WDCR_MF_NS + `WDCR_CLK_NS - 1) / `WDCR_CLK_NS)
`define WDCR_BASE_SHIFT   5
`define WDCR_MAX_SHIFT    18

`endif

// ### hw/wdcr_pkg.sv
// types of the watchdog count readback block
// assumes nothing of its surroundings
package wdcr_pkg;

  // ****************************************************
  // watchdog arming state, one-hot
  // ****************************************************
  typedef enum logic [1:0] {
    WDCR_DISARMED = 2'b01,
    WDCR_ARMED    = 2'b10
  } wdcr_state_t;

  typedef logic [2:0] wdcr_clksel_t;  // watchdog clock select code

endpackage

// ### hw/wdcr_tick_if.sv
// interface carrying the selected watchdog clock tick between divider and core
// assumes both ends run on the one system clock
`timescale 1ns/100ps
interface wdcr_tick_if;
  import wdcr_pkg::*;
  wdcr_clksel_t clockSelect;  // chosen watchdog clock source
  logic         tick;         // one-cycle enable per watchdog clock period

  modport src (input clockSelect, output tick);
  modport dst (output clockSelect, input tick);
endinterface

// ### hw/wdcr_tick_div.sv
// divider that turns the system clock into the selected watchdog clock tick
// assumes a synchronous active-high reset and a 20 MHz clock
`timescale 1ns/100ps
`include "wdcr_defs.svh"
module wdcr_tick_div #(
  parameter int LF_CYCLES = `WDCR_LF_CYC,
  parameter int MF_CYCLES = `WDCR_MF_CYC
) (
  input  wire logic clk,
  input  wire logic reset,
  wdcr_tick_if.src  tickIf
);
  import wdcr_pkg::*;

  logic [15:0] divCount;       // cycles since last tick
  logic [15:0] next_divCount;
  logic [15:0] divEnd;         // last count of the selected period

  // ****************************************************
  // period select and counter
  // ****************************************************
  // reserved select codes fall back to the slow source
  always_comb begin
    if (tickIf.clockSelect == 3'h1) begin
      divEnd = 16'(MF_CYCLES - 1);
    end else begin
      divEnd = 16'(LF_CYCLES - 1);
    end
    // a select change mid-period may stretch one period; harmless for a watchdog
    if (divCount >= divEnd) begin
      next_divCount = 16'h0000;
    end else begin
      next_divCount = divCount + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      divCount <= 16'h0000;
    end else begin
      divCount <= next_divCount;
    end
  end

  assign tickIf.tick = (divCount >= divEnd);

endmodule // wdcr_tick_div

// ### hw/wdcr_top.sv
// watchdog prescale and count readback with its control registers on APB
// assumes an APB master on clk, synchronous active-high reset, 20 MHz clock
//
// Contract
// - 18-bit prescale count spread over three registers
// - low register returns prescale bits 7:0
// - high register returns prescale bits 15:8
// - timer register bits 1:0 hold prescale 17:16
// - timer register bits 6:3 hold watchdog count
// - timer register bit 2 shows armed state
// - timer register bit 7 reads zero
// - readback registers read-only, zero after reset
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "wdcr_defs.svh"
module wdcr_top #(
  parameter int LF_CYCLES = `WDCR_LF_CYC,
  parameter int MF_CYCLES = `WDCR_MF_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output wdcr_pkg::wdcr_state_t armedState
);
  import wdcr_pkg::*;

  // ****************************************************
  // declarations
  // ****************************************************
  wdcr_tick_if tickIf ();

  logic        softwareEnable;       // arms the watchdog
  logic [4:0]  periodSelect;         // prescale period code
  wdcr_clksel_t watchdogClockSelect; // tick source code
  logic [2:0]  windowSelect;         // stored only, no window logic here
  logic [17:0] prescaleCount;        // running prescaler
  logic [3:0]  watchdogCountValue;   // running count value
  wdcr_state_t state;                // armed or not
  logic        next_softwareEnable;
  logic [4:0]  next_periodSelect;
  wdcr_clksel_t next_watchdogClockSelect;
  logic [2:0]  next_windowSelect;
  logic [17:0] next_prescaleCount;
  logic [3:0]  next_watchdogCountValue;
  wdcr_state_t next_state;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        setupPhase;           // first cycle of a transfer
  logic        writeTaken;           // write takes effect now
  logic [17:0] prescaleEnd;          // last prescale value of a period

  // ****************************************************
  // decode helpers
  // ****************************************************
  // true for any address that holds a register
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `WDCR_OFF_PERIOD) || (a == `WDCR_OFF_CLKWIN) || (a == `WDCR_OFF_PSLOW) ||
               (a == `WDCR_OFF_PSHIGH) || (a == `WDCR_OFF_TIMER);
  endfunction

  // period length is 32 ticks doubled per code step, capped at the prescaler width
  function automatic logic [17:0] periodLast(input logic [4:0] ps);
    logic [4:0] sh;
    sh = 5'(`WDCR_BASE_SHIFT) + ps;
    if (ps > 5'(`WDCR_MAX_SHIFT - `WDCR_BASE_SHIFT)) begin
      sh = 5'(`WDCR_MAX_SHIFT);
    end
    periodLast = 18'((19'h00001 << sh) - 19'h00001);
  endfunction

  assign setupPhase  = psel && !penable;
  assign writeTaken  = psel && penable && pwrite;
  assign pready      = 1'b1;  // zero wait states; answer in the access cycle
  assign prescaleEnd = periodLast(periodSelect);
  assign armedState  = state;
  assign tickIf.clockSelect = watchdogClockSelect;

  wdcr_tick_div #(
    .LF_CYCLES (LF_CYCLES),
    .MF_CYCLES (MF_CYCLES)
  ) u_tick (
    .clk    (clk),
    .reset  (reset),
    .tickIf (tickIf)
  );

  // ****************************************************
  // control registers
  // ****************************************************
  // readback registers have no write path at all
  always_comb begin
    next_softwareEnable      = softwareEnable;
    next_periodSelect        = periodSelect;
    next_watchdogClockSelect = watchdogClockSelect;
    next_windowSelect        = windowSelect;
    if (writeTaken) begin
      case (paddr)
        `WDCR_OFF_PERIOD: begin
          next_softwareEnable = pwdata[`WDCR_SEN_BIT];
          next_periodSelect   = pwdata[`WDCR_PS_MSB:`WDCR_PS_LSB];
        end
        `WDCR_OFF_CLKWIN: begin
          next_watchdogClockSelect = pwdata[`WDCR_CS_MSB:`WDCR_CS_LSB];
          next_windowSelect        = pwdata[`WDCR_WIN_MSB:`WDCR_WIN_LSB];
        end
        default: begin
          next_softwareEnable = softwareEnable;  // readback or unmapped: ignored
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      softwareEnable      <= 1'b0;
      periodSelect        <= `WDCR_RST_PS;
      watchdogClockSelect <= `WDCR_RST_CS;
      windowSelect        <= `WDCR_RST_WIN;
    end else begin
      softwareEnable      <= next_softwareEnable;
      periodSelect        <= next_periodSelect;
      watchdogClockSelect <= next_watchdogClockSelect;
      windowSelect        <= next_windowSelect;
    end
  end

  // ****************************************************
  // watchdog counting
  // ****************************************************
  // disarming clears both counters so a re-arm starts a fresh period
  always_comb begin
    next_state              = state;
    next_prescaleCount      = prescaleCount;
    next_watchdogCountValue = watchdogCountValue;
    case (state)
      WDCR_DISARMED: begin
        next_prescaleCount      = `WDCR_RST_PRESCALE_COUNT;
        next_watchdogCountValue = `WDCR_RST_CNT;
        if (softwareEnable) begin
          next_state = WDCR_ARMED;
        end
      end
      WDCR_ARMED: begin
        if (!softwareEnable) begin
          next_state = WDCR_DISARMED;
        end else if (tickIf.tick) begin
          if (prescaleCount >= prescaleEnd) begin
            next_prescaleCount      = `WDCR_RST_PRESCALE_COUNT;
            next_watchdogCountValue = watchdogCountValue + 4'h1;
          end else begin
            next_prescaleCount = prescaleCount + 18'h00001;
          end
        end
      end
      default: begin
        next_state = WDCR_DISARMED;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state              <= WDCR_DISARMED;
      prescaleCount      <= `WDCR_RST_PRESCALE_COUNT;
      watchdogCountValue <= `WDCR_RST_CNT;
    end else begin
      state              <= next_state;
      prescaleCount      <= next_prescaleCount;
      watchdogCountValue <= next_watchdogCountValue;
    end
  end

  // ****************************************************
  // APB read path
  // ****************************************************
  // data latched in setup so it stands still through the access cycle
  always_comb begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (setupPhase) begin
      next_pslverr = !isMapped(paddr);
      next_prdata  = 32'h00000000;
      case (paddr)
        `WDCR_OFF_PERIOD: begin
          next_prdata[`WDCR_PS_MSB:`WDCR_PS_LSB] = periodSelect;
          next_prdata[`WDCR_SEN_BIT]             = softwareEnable;
        end
        `WDCR_OFF_CLKWIN: begin
          next_prdata[`WDCR_CS_MSB:`WDCR_CS_LSB]   = watchdogClockSelect;
          next_prdata[`WDCR_WIN_MSB:`WDCR_WIN_LSB] = windowSelect;
        end
        `WDCR_OFF_PSLOW: begin
          next_prdata[7:0] = prescaleCount[7:0];
        end
        `WDCR_OFF_PSHIGH: begin
          next_prdata[7:0] = prescaleCount[15:8];
        end
        `WDCR_OFF_TIMER: begin
          next_prdata[1:0] = prescaleCount[17:16];
          next_prdata[`WDCR_TMR_ARMED] = (state == WDCR_ARMED);
          next_prdata[`WDCR_TMR_CNT_MSB:`WDCR_TMR_CNT_LSB] = watchdogCountValue;
          next_prdata[7] = 1'b0;
        end
        default: begin
          next_prdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  property p_low_read;
    @(posedge clk) disable iff (reset)
    (setupPhase && paddr == `WDCR_OFF_PSLOW) |=> (prdata == {24'h000000, $past(prescaleCount[7:0])});
  endproperty
  a_low_read: assert property (p_low_read) else $error("low prescale readback wrong");

  property p_high_read;
    @(posedge clk) disable iff (reset)
    (setupPhase && paddr == `WDCR_OFF_PSHIGH) |=> (prdata == {24'h000000, $past(prescaleCount[15:8])});
  endproperty
  a_high_read: assert property (p_high_read) else $error("high prescale readback wrong");

  property p_tmr_low;
    @(posedge clk) disable iff (reset)
    (setupPhase && paddr == `WDCR_OFF_TIMER) |=> (prdata[1:0] == $past(prescaleCount[17:16]));
  endproperty
  a_tmr_low: assert property (p_tmr_low) else $error("timer register prescale bits wrong");

  property p_tmr_cnt;
    @(posedge clk) disable iff (reset)
    (setupPhase && paddr == `WDCR_OFF_TIMER) |=> (prdata[6:3] == $past(watchdogCountValue));
  endproperty
  a_tmr_cnt: assert property (p_tmr_cnt) else $error("timer register count bits wrong");

  // status bit must mirror the arming state seen at the setup edge
  property p_tmr_armed;
    @(posedge clk) disable iff (reset)
    (setupPhase && paddr == `WDCR_OFF_TIMER) |=> (prdata[`WDCR_TMR_ARMED] == ($past(state) == WDCR_ARMED));
  endproperty
  a_tmr_armed: assert property (p_tmr_armed) else $error("armed status bit wrong");

  // enable held high means armed one clock later
  property p_arm_follow;
    @(posedge clk) disable iff (reset)
    softwareEnable |=> (state == WDCR_ARMED);
  endproperty
  a_arm_follow: assert property (p_arm_follow) else $error("armed state does not follow enable");

  property p_tmr_top;
    @(posedge clk) disable iff (reset)
    (psel && penable && paddr == `WDCR_OFF_TIMER) |-> (prdata[31:7] == 25'h0000000);
  endproperty
  a_tmr_top: assert property (p_tmr_top) else $error("timer register top bits not zero");

  property p_reset_zero;
    @(posedge clk)
    reset |=> (prescaleCount == 18'h00000 && watchdogCountValue == 4'h0 && state == WDCR_DISARMED);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("readback not zero after reset");

  property p_ro_write;
    @(posedge clk) disable iff (reset)
    (writeTaken && !tickIf.tick && state == WDCR_ARMED && softwareEnable && paddr == `WDCR_OFF_PSLOW)
      |=> (prescaleCount == $past(prescaleCount));
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("write changed readback");

  property p_prescale_step;
    @(posedge clk) disable iff (reset)
    (state == WDCR_ARMED && softwareEnable && tickIf.tick && prescaleCount < prescaleEnd)
      |=> (prescaleCount == $past(prescaleCount) + 18'h00001);
  endproperty
  a_prescale_step: assert property (p_prescale_step) else $error("prescaler did not step on tick");

  property p_count_step;
    @(posedge clk) disable iff (reset)
    (state == WDCR_ARMED && softwareEnable && tickIf.tick && prescaleCount >= prescaleEnd)
      |=> (prescaleCount == 18'h00000 && watchdogCountValue == $past(watchdogCountValue) + 4'h1);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not advance at period end");

  // only checked right after a tick under an unchanged period; a shorter period
  // written while armed may leave the count above the end until the next tick
  property p_prescale_bound;
    @(posedge clk) disable iff (reset)
    (state == WDCR_ARMED && $past(tickIf.tick) && $stable(periodSelect)) |-> (prescaleCount <= prescaleEnd);
  endproperty
  a_prescale_bound: assert property (p_prescale_bound) else $error("prescaler past period end");

endmodule // wdcr_top

// ### verif/wdcr_top_tb.sv
// self-checking bench for the watchdog count readback block, driven as an apb master
// assumes wdcr_top with shortened tick dividers; offsets come from wdcr_defs.svh, field values are written out
`timescale 1ns/100ps
`include "wdcr_defs.svh"
module wdcr_top_tb;
  import wdcr_pkg::*;

  // ****************************************************
  // parameters, signals and bookkeeping
  // ****************************************************
  localparam int LF = 4;                // clocks per tick on clock select 0
  localparam int MF = 3;                // clocks per tick on clock select 1
  logic        clk;                     // 20 mhz system clock
  logic        reset;                   // synchronous, active high
  logic        psel;                    // apb select
  logic        penable;                 // apb access phase
  logic        pwrite;                  // apb direction
  logic [7:0]  paddr;                   // apb byte address
  logic [31:0] pwdata;                  // apb write data
  logic [31:0] prdata;                  // apb read data
  logic        pready;                  // apb ready
  logic        pslverr;                 // apb error
  wdcr_state_t armedState;              // one-hot arming state
  int          mismatches  = 0;         // failed comparisons
  int          checksDone  = 0;         // all comparisons
  int          cyc         = 0;         // rising edges seen so far
  int          lastEdge;                // edge number of the last access phase
  int          armEdge;                 // access edge of the arming write
  int          i;                       // loop index
  logic [31:0] d;                       // read data scratch
  logic [31:0] h;                       // high byte scratch
  logic [31:0] t;                       // timer register scratch
  logic        e;                       // error flag scratch
  logic [7:0]  roAddr [3] = '{`WDCR_OFF_PSLOW, `WDCR_OFF_PSHIGH, `WDCR_OFF_TIMER};  // readback registers

  wdcr_top #(.LF_CYCLES(LF), .MF_CYCLES(MF)) dut (
    .clk        (clk),
    .reset      (reset),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .armedState (armedState)
  );

  // clock and edge counter; the counter lets waits be counted in edges from the arming write
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  // ****************************************************
  // comparison and closing tasks
  // ****************************************************
  task automatic finishTest();
    $display("comparisons %0d, mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // range test for values whose tick phase is not known to the cycle
  task automatic checkRange(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi, input string what);
    checksDone++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h outside %h..%h", $time, what, got, lo, hi);
    end
  endtask

  // ****************************************************
  // apb master: setup, access until pready, then release
  // ****************************************************
  task automatic apbXfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                         output logic [31:0] rdata, output logic err);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      mismatches++;
      $display("wrong value at %0t: pready never came", $time);
      finishTest();
    end
    rdata    = prdata;
    err      = pslverr;
    lastEdge = cyc;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
    logic [31:0] r;
    logic        x;
    apbXfer(1'b1, addr, wdata, r, x);
  endtask

  task automatic rd(input logic [7:0] addr, output logic [31:0] rdata);
    logic x;
    apbXfer(1'b0, addr, 32'h0, rdata, x);
  endtask

  // idle so that the next transfer's setup edge is edge number edgeNo
  task automatic waitUntil(input int edgeNo);
    repeat (edgeNo - cyc - 1) @(posedge clk);
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    reset   = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // zero after reset, writes ignored without error
    for (i = 0; i < 3; i++) begin
      rd(roAddr[i], d);
      check(d, 32'h0, "readback after reset");
      apbXfer(1'b1, roAddr[i], 32'hFFFF_FFFF, d, e);
      check({31'h0, e}, 32'h0, "error on readonly write");
      rd(roAddr[i], d);
      check(d, 32'h0, "readback after write");
    end
    check({30'h0, armedState}, {30'h0, WDCR_DISARMED}, "state after reset");
    rd(`WDCR_OFF_CLKWIN, d);
    check(d, 32'h07, "clock/window reset value");
    // unmapped address: error, zero data
    apbXfer(1'b0, 8'h14, 32'h0, d, e);
    check({31'h0, e}, 32'h1, "unmapped read error");
    check(d, 32'h0, "unmapped read data");
    // period 32 ticks on select 0: count 5 after 176 ticks, wraps back to 5 after 688
    wr(`WDCR_OFF_PERIOD, 32'h01);
    armEdge = lastEdge;
    waitUntil(armEdge + LF * 176);
    rd(`WDCR_OFF_TIMER, d);
    check(d, 32'h2C, "timer at count 5");
    rd(`WDCR_OFF_PSLOW, d);
    checkRange(d, 32'd14, 32'd19, "prescale inside period");
    check({30'h0, armedState}, {30'h0, WDCR_ARMED}, "armed state");
    waitUntil(armEdge + LF * 688);
    rd(`WDCR_OFF_TIMER, d);
    check(d, 32'h2C, "timer after count wrap");
    // disarming clears count and prescale
    wr(`WDCR_OFF_PERIOD, 32'h00);
    @(posedge clk);  // state drops one clock after the write, counters one clock later
    rd(`WDCR_OFF_TIMER, d);
    check(d, 32'h0, "timer after disarm");
    rd(`WDCR_OFF_PSLOW, d);
    check(d, 32'h0, "prescale after disarm");
    // long period on select 1: about 1000 ticks spread over three registers
    wr(`WDCR_OFF_CLKWIN, 32'h17);
    wr(`WDCR_OFF_PERIOD, 32'h1B);
    armEdge = lastEdge;
    waitUntil(armEdge + MF * 1000);
    rd(`WDCR_OFF_PSLOW, d);
    rd(`WDCR_OFF_PSHIGH, h);
    rd(`WDCR_OFF_TIMER, t);
    checkRange({14'h0, t[1:0], h[7:0], d[7:0]}, 32'd997, 32'd1003, "18-bit prescale");
    check(h, 32'h03, "prescale high byte");
    check(t & 32'hFFFF_FFFC, 32'h04, "timer upper bits");
    // a write while armed must not disturb the running prescaler
    wr(`WDCR_OFF_PSLOW, 32'h0);
    // 40 ticks later exactly, same tick phase: low byte wraps, high byte steps
    waitUntil(armEdge + MF * 1040);
    rd(`WDCR_OFF_PSLOW, t);
    check(t, (d + 32'd40) & 32'hFF, "prescale low after 40 ticks");
    rd(`WDCR_OFF_PSHIGH, h);
    check(h, 32'h04, "prescale high after carry");
    // reset in mid-run returns the readback registers to zero and disarms
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 3; i++) begin
      rd(roAddr[i], d);
      check(d, 32'h0, "readback after second reset");
    end
    check({30'h0, armedState}, {30'h0, WDCR_DISARMED}, "state after second reset");
    finishTest();
  end
endmodule // wdcr_top_tb
